// [hw/wake_timer_pkg.sv]
// Constants and types for the halt auto-wakeup timer
// What this block does
// (RULE1) A halt instruction with the wake timer enable bit set enters timed halt mode.
// (RULE2) A halt instruction with the enable bit clear and active-halt disabled enters ordinary halt.
// (RULE3) In timed halt the wake RC clock runs through a fixed divider and a programmable prescaler.
// (RULE4) When the prescaled delay elapses the elapsed flag is set and a wake interrupt is raised.
// (RULE5) On wake the main oscillator starts at once and 256 or 4096 cycles pass before the CPU resumes.
// (RULE6) After stabilisation the CPU resumes by servicing the wake interrupt when the elapsed flag is set, else it returns straight to run.
// (RULE7) A read of the wake control/status register clears the elapsed flag and its interrupt.
// (RULE8) In run mode the measure select bit routes the wake RC clock to the timer input capture.
// (RULE9) Software may calibrate the prescaler by measuring the wake RC clock.
// (RULE10) Timed halt is left on any halt-exit interrupt or on reset.
// (RULE11) Entering halt forces the interrupt mask to 0, so a pending interrupt wakes at once.
// (RULE12) In halt the main oscillator is off and peripherals are unclocked.
// (RULE13) A halt with the watchdog enabled and active-halt disabled gives a watchdog reset according to the halt option bit.
package wake_timer_pkg;
   localparam int unsigned FIXED_DIV   = 16;
   localparam int unsigned STAB_SHORT  = 256;
   localparam int unsigned STAB_LONG   = 4096;
   localparam int unsigned CNT_W       = 13;
   localparam logic [7:0]  PRESC_RESET = 8'h00;
   typedef enum logic [2:0] {
      st_run    = 3'b000,
      st_halt   = 3'b001,
      st_timed  = 3'b010,
      st_stab   = 3'b011,
      st_vector = 3'b100
   } state_type;
endpackage

// [hw/halt_auto_wakeup_timer.sv]
// Halt auto-wakeup sequencer with wake RC tick prescaling and oscillator stabilisation
`timescale 1ns/1ps
module halt_auto_wakeup_timer
   import wake_timer_pkg::*;
#(
   parameter int unsigned STAB_LONG_CYCLES = STAB_LONG
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // CPU side
   input  wire logic       halt_exec,
   input  wire logic       csr_read,
   input  wire logic       wake_timer_enable_bit,
   input  wire logic       wake_clock_measure_select,
   input  wire logic [7:0] wake_prescaler_register,
   input  wire logic       active_halt_enable,
   input  wire logic       long_stab_select,
   input  wire logic       irq_pending,
   input  wire logic       halt_exit_irq,
   input  wire logic       watchdog_enabled,
   input  wire logic       watchdog_halt_option,
   // Wake RC clock, sampled as a synchronous tick
   input  wire logic       wake_rc_clock,
   // Outputs
   output logic            wake_elapsed_flag,
   output logic            wake_irq,
   output logic            vector_wake,
   output logic            main_osc_on,
   output logic            periph_clock_en,
   output logic            cpu_run,
   output logic            irq_mask_clear,
   output logic            watchdog_reset,
   output logic            capture_in,
   output logic [2:0]      mode
);
   localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(STAB_SHORT - 1);
   localparam logic [CNT_W-1:0] LONG_LAST  = CNT_W'(STAB_LONG_CYCLES - 1);
   localparam logic [4:0]       DIV_LAST   = 5'(FIXED_DIV - 1);

   state_type        state_q;
   logic             rc_q;
   logic             rc_edge;
   logic [4:0]       div_q;
   logic [7:0]       presc_q;
   logic [CNT_W-1:0] stab_q;
   logic             flag_q;
   logic             wdg_q;
   logic             elapsed;
   logic             stab_done;

   assign rc_edge   = wake_rc_clock & ~rc_q;
   assign elapsed   = (state_q == st_timed) && rc_edge && (div_q == DIV_LAST)
                      && (presc_q == wake_prescaler_register); // RULE3
   assign stab_done = (state_q == st_stab) &&
                      (stab_q == (long_stab_select ? LONG_LAST : SHORT_LAST)); // RULE5

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rc_q <= 1'b0;
      end else begin
         rc_q <= wake_rc_clock;
      end
   end

   // Sequencer; reset leaves halt through nrst
   always_ff @(posedge clock or negedge nrst) begin // RULE10
      if (!nrst) begin
         state_q <= st_run;
      end else begin
         case (state_q)
            st_run: begin
               if (halt_exec && !irq_pending) begin // RULE11
                  if (wake_timer_enable_bit) begin
                     state_q <= st_timed; // RULE1
                  end else if (!active_halt_enable) begin
                     state_q <= st_halt; // RULE2
                  end
               end
            end
            st_halt: begin
               if (halt_exit_irq) begin
                  state_q <= st_stab; // RULE10
               end
            end
            st_timed: begin
               if (elapsed || halt_exit_irq) begin
                  state_q <= st_stab; // RULE4
               end
            end
            st_stab: begin
               if (stab_done) begin
                  state_q <= flag_q ? st_vector : st_run; // RULE6
               end
            end
            st_vector: begin
               state_q <= st_run;
            end
            default: begin
               state_q <= st_run;
            end
         endcase
      end
   end

   // Fixed divider then programmable prescaler, both cleared outside timed halt
   always_ff @(posedge clock or negedge nrst) begin // RULE3
      if (!nrst) begin
         div_q   <= 5'h00;
         presc_q <= PRESC_RESET;
      end else if (state_q != st_timed) begin
         div_q   <= 5'h00;
         presc_q <= PRESC_RESET;
      end else if (rc_edge) begin
         if (div_q == DIV_LAST) begin
            div_q   <= 5'h00;
            presc_q <= (presc_q == wake_prescaler_register) ? PRESC_RESET : presc_q + 8'h01;
         end else begin
            div_q <= div_q + 5'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin // RULE5
      if (!nrst) begin
         stab_q <= '0;
      end else if (state_q == st_stab) begin
         stab_q <= stab_q + CNT_W'(1);
      end else begin
         stab_q <= '0;
      end
   end

   // Set wins over the read-clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flag_q <= 1'b0;
      end else if (elapsed) begin
         flag_q <= 1'b1; // RULE4
      end else if (csr_read) begin
         flag_q <= 1'b0; // RULE7
      end
   end

   always_ff @(posedge clock or negedge nrst) begin // RULE13
      if (!nrst) begin
         wdg_q <= 1'b0;
      end else begin
         wdg_q <= (state_q == st_run) && halt_exec && watchdog_enabled
                  && !watchdog_halt_option && !active_halt_enable;
      end
   end

   assign wake_elapsed_flag = flag_q;
   assign wake_irq          = flag_q; // RULE4
   assign vector_wake       = (state_q == st_vector); // RULE6
   assign main_osc_on       = (state_q != st_halt) && (state_q != st_timed); // RULE12
   assign periph_clock_en   = main_osc_on; // RULE12
   assign cpu_run           = (state_q == st_run) || (state_q == st_vector);
   assign irq_mask_clear    = (state_q == st_run) && halt_exec; // RULE11
   assign watchdog_reset    = wdg_q;
   assign capture_in        = (state_q == st_run) && wake_clock_measure_select
                              && wake_rc_clock; // RULE8
   assign mode              = state_q;

   chk_timed_entry: assert property (@(posedge clock) disable iff (!nrst) // RULE1
      (state_q == st_run && halt_exec && !irq_pending && wake_timer_enable_bit)
      |=> state_q == st_timed) else $error("timed halt not entered");
   chk_plain_entry: assert property (@(posedge clock) disable iff (!nrst) // RULE2
      (state_q == st_run && halt_exec && !irq_pending && !wake_timer_enable_bit
       && !active_halt_enable) |=> state_q == st_halt) else $error("halt not entered");
   chk_flag_set: assert property (@(posedge clock) disable iff (!nrst) // RULE4
      elapsed |=> wake_elapsed_flag && state_q == st_stab) else $error("elapsed flag missing");
   sequence stab_short_seq;
      (state_q == st_stab && !long_stab_select) [*8];
   endsequence
   chk_osc_on: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      stab_short_seq |-> main_osc_on && !cpu_run) else $error("cpu ran during stabilisation");
   chk_vector: assert property (@(posedge clock) disable iff (!nrst) // RULE6
      (stab_done && flag_q) |=> vector_wake ##1 cpu_run) else $error("no wake vector");
   chk_read_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE7
      (csr_read && !elapsed) |=> !wake_elapsed_flag && !wake_irq) else $error("flag not cleared");
   chk_measure: assert property (@(posedge clock) disable iff (!nrst) // RULE8
      capture_in |-> state_q == st_run && wake_clock_measure_select) else $error("capture leak");
   chk_exit_irq: assert property (@(posedge clock) disable iff (!nrst) // RULE10
      (state_q == st_halt && halt_exit_irq) |=> state_q == st_stab) else $error("no exit");
   chk_pending: assert property (@(posedge clock) disable iff (!nrst) // RULE11
      (state_q == st_run && halt_exec && irq_pending) |=> state_q == st_run)
      else $error("halted with pending irq");
   chk_osc_off: assert property (@(posedge clock) disable iff (!nrst) // RULE12
      (state_q == st_timed) |-> !main_osc_on && !periph_clock_en) else $error("osc on in halt");
   chk_watchdog: assert property (@(posedge clock) disable iff (!nrst) // RULE13
      (state_q == st_run && halt_exec && watchdog_enabled && watchdog_halt_option)
      |=> !watchdog_reset) else $error("unexpected watchdog reset");

   // Checker-only counts, kept apart from the sequencer so the delay checks
   // do not simply restate the counters they are meant to judge
   logic [CNT_W-1:0] rc_seen_q;
   logic [CNT_W-1:0] stab_seen_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rc_seen_q <= '0;
      end else if (state_q != st_timed) begin
         rc_seen_q <= '0;
      end else if (rc_edge) begin
         rc_seen_q <= rc_seen_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stab_seen_q <= '0;
      end else if (state_q == st_stab) begin
         stab_seen_q <= stab_seen_q + CNT_W'(1);
      end else begin
         stab_seen_q <= '0;
      end
   end

   sequence timed_halt_seq;
      state_q == st_run && halt_exec && !irq_pending && wake_timer_enable_bit;
   endsequence
   sequence wake_seq;
      elapsed;
   endsequence

   // Entry and refusal
   chk_refused_active: assert property (@(posedge clock) disable iff (!nrst) // RULE2
      (state_q == st_run && halt_exec && !wake_timer_enable_bit && active_halt_enable)
      |=> state_q == st_run) else $error("halt taken with active halt enabled");
   chk_timed_path: assert property (@(posedge clock) disable iff (!nrst) // RULE12
      timed_halt_seq |=> !main_osc_on && !cpu_run)
      else $error("oscillator left on after timed halt entry");
   chk_mask_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE11
      (state_q == st_run && halt_exec) |-> irq_mask_clear)
      else $error("interrupt mask not cleared at halt");
   chk_mask_idle: assert property (@(posedge clock) disable iff (!nrst) // RULE11
      !halt_exec |-> !irq_mask_clear)
      else $error("interrupt mask cleared without halt");

   // Wake delay
   chk_divider_range: assert property (@(posedge clock) disable iff (!nrst) // RULE3
      div_q <= DIV_LAST)
      else $error("fixed divider out of range");
   chk_count_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE3
      (state_q == st_run) |-> div_q == 5'h00 && presc_q == PRESC_RESET)
      else $error("wake counters not cleared in run");
   chk_rc_delay: assert property (@(posedge clock) disable iff (!nrst) // RULE3
      elapsed |-> rc_seen_q == CNT_W'((32'(wake_prescaler_register) + 1) * FIXED_DIV - 1))
      else $error("wake delay length wrong");
   chk_timed_stays: assert property (@(posedge clock) disable iff (!nrst) // RULE3
      (state_q == st_timed && !elapsed && !halt_exit_irq) |=> state_q == st_timed)
      else $error("timed halt left early");
   chk_timed_exit: assert property (@(posedge clock) disable iff (!nrst) // RULE10
      (state_q == st_timed && halt_exit_irq) |=> state_q == st_stab)
      else $error("timed halt ignored exit interrupt");
   chk_halt_stays: assert property (@(posedge clock) disable iff (!nrst) // RULE10
      (state_q == st_halt && !halt_exit_irq) |=> state_q == st_halt)
      else $error("halt left without interrupt");

   // Flag and interrupt
   chk_irq_mirror: assert property (@(posedge clock) disable iff (!nrst) // RULE4
      wake_irq == wake_elapsed_flag)
      else $error("wake interrupt differs from flag");
   chk_flag_cause: assert property (@(posedge clock) disable iff (!nrst) // RULE4
      (!wake_elapsed_flag && !elapsed) |=> !wake_elapsed_flag)
      else $error("flag set without elapsed delay");
   chk_flag_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE7
      (wake_elapsed_flag && !csr_read) |=> wake_elapsed_flag)
      else $error("flag lost without read");

   // Stabilisation and resume
   chk_wake_osc: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      wake_seq |=> main_osc_on && !cpu_run)
      else $error("oscillator not started on wake");
   chk_stab_hold: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      (state_q == st_stab && !stab_done) |=> state_q == st_stab)
      else $error("stabilisation cut short");
   chk_stab_count: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      (state_q == st_stab && !stab_done) |=> stab_q == $past(stab_q) + CNT_W'(1))
      else $error("stabilisation counter skipped");
   chk_stab_length: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      (state_q == st_stab) |-> stab_seen_q <= (long_stab_select ? LONG_LAST : SHORT_LAST))
      else $error("stabilisation too long");
   chk_cpu_stopped: assert property (@(posedge clock) disable iff (!nrst) // RULE5
      (state_q == st_halt || state_q == st_timed || state_q == st_stab) |-> !cpu_run)
      else $error("cpu running while halted");
   chk_vector_once: assert property (@(posedge clock) disable iff (!nrst) // RULE6
      vector_wake |=> !vector_wake && state_q == st_run)
      else $error("wake vector longer than one cycle");
   chk_vector_flag: assert property (@(posedge clock) disable iff (!nrst) // RULE6
      vector_wake |-> wake_irq && cpu_run)
      else $error("wake vector without interrupt");
   chk_plain_resume: assert property (@(posedge clock) disable iff (!nrst) // RULE6
      (stab_done && !flag_q) |=> state_q == st_run && !vector_wake)
      else $error("vector taken without wake flag");

   // Oscillator, measurement and watchdog
   chk_halt_osc_off: assert property (@(posedge clock) disable iff (!nrst) // RULE12
      (state_q == st_halt) |-> !main_osc_on && !periph_clock_en)
      else $error("oscillator on in plain halt");
   chk_capture_off: assert property (@(posedge clock) disable iff (!nrst) // RULE8
      (state_q != st_run) |-> !capture_in)
      else $error("capture driven outside run");
   chk_watchdog_fire: assert property (@(posedge clock) disable iff (!nrst) // RULE13
      (state_q == st_run && halt_exec && watchdog_enabled && !watchdog_halt_option
       && !active_halt_enable) |=> watchdog_reset)
      else $error("watchdog reset missing");
endmodule

// [testbench/halt_auto_wakeup_timer_tb_top.sv]
// Self-checking testbench for the halt auto-wakeup timer
`timescale 1ns/1ps
module halt_auto_wakeup_timer_tb_top import wake_timer_pkg::*; ();
   logic clock = 0, nrst = 0, halt_exec = 0, csr_read = 0, enable = 0, measure = 0;
   logic [7:0] presc = 8'h00;
   logic active_halt = 0, long_stab = 0, irq_pending = 0, exit_irq = 0, wd_en = 0, wd_opt = 0;
   logic [1:0] rc_cnt = 2'h0;
   logic wake_rc_clock, flag, wake_irq, vector_wake, osc_on, periph_en, cpu_run, mask_clr;
   logic wd_reset, capture_in;
   logic [2:0] mode;
   int mismatches = 0, samples_checked = 0, n;
   always #10 clock = ~clock;
   // RC clock runs at a quarter of the system clock
   always @(posedge clock) #1 rc_cnt = rc_cnt + 2'h1;
   assign wake_rc_clock = rc_cnt[1];
   halt_auto_wakeup_timer #(.STAB_LONG_CYCLES(16)) uut (.clock(clock), .nrst(nrst),
      .halt_exec(halt_exec), .csr_read(csr_read), .wake_timer_enable_bit(enable),
      .wake_clock_measure_select(measure), .wake_prescaler_register(presc),
      .active_halt_enable(active_halt), .long_stab_select(long_stab), .irq_pending(irq_pending),
      .halt_exit_irq(exit_irq), .watchdog_enabled(wd_en), .watchdog_halt_option(wd_opt),
      .wake_rc_clock(wake_rc_clock), .wake_elapsed_flag(flag), .wake_irq(wake_irq),
      .vector_wake(vector_wake), .main_osc_on(osc_on), .periph_clock_en(periph_en),
      .cpu_run(cpu_run), .irq_mask_clear(mask_clr), .watchdog_reset(wd_reset),
      .capture_in(capture_in), .mode(mode));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic step;
      @(posedge clock);
      #1;
   endtask
   task automatic halt_pulse;
      halt_exec = 1;
      step;
      halt_exec = 0;
   endtask
   // Bounded wait; n is the number of cycles spent
   task automatic wait_mode(input logic [2:0] s);
      n = 0;
      while (mode !== s && n < 5000) begin
         step;
         n++;
      end
      if (n >= 5000) begin
         chk("timeout", 16'h0, 16'h1);
         results;
      end
   endtask
   task automatic t_timed;
      enable = 1;
      presc = 8'h01;
      long_stab = 1;
      halt_pulse;
      chk("mode", st_timed, mode);
      chk("osc_off", 0, {osc_on, periph_en});
      wait_mode(st_stab);
      chk("delay", 1, (n >= 120 && n <= 136));
      chk("flag_irq", 16'h3, {flag, wake_irq});
      chk("osc_on", 1, osc_on);
      wait_mode(st_vector);
      chk("stab_len", 16, n);
      chk("vector", 16'h3, {vector_wake, cpu_run});
      step;
      chk("back_run", st_run, mode);
      csr_read = 1;
      step;
      csr_read = 0;
      chk("flag_clear", 0, {flag, wake_irq});
      enable = 0;
      long_stab = 0;
   endtask
   task automatic t_halt;
      halt_pulse;
      chk("mode", st_halt, mode);
      exit_irq = 1;
      step;
      exit_irq = 0;
      chk("exit", st_stab, mode);
      wait_mode(st_run);
      chk("short_stab", 256, n);
   endtask
   task automatic t_refuse;
      active_halt = 1;
      halt_pulse;
      chk("active_halt", st_run, mode);
      active_halt = 0;
      enable = 1;
      irq_pending = 1;
      step;
      halt_exec = 1;
      #1 chk("mask_clear", 1, mask_clr);
      step;
      halt_exec = 0;
      irq_pending = 0;
      enable = 0;
      chk("pending", st_run, mode);
   endtask
   task automatic t_measure;
      measure = 1;
      repeat (8) begin
         step;
         #1 chk("capture", wake_rc_clock, capture_in);
      end
      measure = 0;
      step;
   endtask
   task automatic t_watchdog;
      wd_en = 1;
      wd_opt = 1;
      irq_pending = 1;
      halt_pulse;
      chk("wd_masked", 0, wd_reset);
      wd_opt = 0;
      irq_pending = 0;
      step;
      halt_pulse;
      chk("wd_reset", 1, wd_reset);
      wd_en = 0;
      nrst = 0;
      step;
      nrst = 1;
      chk("reset_exit", st_run, mode);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1 nrst = 1;
      chk("reset", {st_run, 2'h3}, {mode, osc_on, cpu_run});
      t_timed;
      t_halt;
      t_refuse;
      t_measure;
      t_watchdog;
      results;
   end
endmodule
